// ---- bench/acr_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module acr_checker (
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   arst_n,
    // Register port
    input wire logic [2:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    // Interrupt and core
    input wire logic                   irq_ack,
    input wire logic                   irq_req,
    input wire acr_pkg::acr_core_req_s core_req,
    input wire logic                   core_enable,
    input wire logic [3:0]             active_channel
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    logic adj_ff;
    logic auto_ff;
    logic ien_ff;

    // Shadow copies of software-owned control bits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            adj_ff <= 1'h0;
        end else if (reg_wr && reg_addr == acr_pkg::ADDR_INPUT_SELECT) begin
            adj_ff <= reg_wdata[acr_pkg::IS_LEFT_ADJ];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_ff <= 1'h0;
            ien_ff  <= 1'h0;
        end else if (reg_wr && reg_addr == acr_pkg::ADDR_CONTROL_A) begin
            auto_ff <= reg_wdata[acr_pkg::CA_AUTO];
            ien_ff  <= reg_wdata[acr_pkg::CA_IRQ_EN];
        end
    end

    sequence s_started;
        core_req.start ##2 1'h1;
    endsequence

    sequence s_read_ctrl;
        reg_rd && reg_addr == acr_pkg::ADDR_CONTROL_A;
    endsequence

    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_enable_holds: assert property (core_req.start |-> core_enable ##1 core_enable [*8])
        else $error("converter disabled during conversion");
    a_start_spacing: assert property (core_req.start |=> !core_req.start [*8])
        else $error("conversion restarted too early");
    a_channel_frozen: assert property (s_started |-> $stable(active_channel) [*8])
        else $error("channel changed during conversion");
    a_right_high_zero: assert property ((reg_rd && reg_addr == acr_pkg::ADDR_RESULT_HIGH
        && !adj_ff) |=> reg_rdata[7:2] == 6'h00)
        else $error("right adjusted high byte has upper bits set");
    a_left_low_zero: assert property ((reg_rd && reg_addr == acr_pkg::ADDR_RESULT_LOW
        && adj_ff) |=> reg_rdata[5:0] == 6'h00)
        else $error("left adjusted low byte has lower bits set");
    a_busy_start_bit: assert property ((core_req.start && !auto_ff) ##[1:20] s_read_ctrl
        |=> reg_rdata[acr_pkg::CA_START])
        else $error("start bit low during conversion");
    a_irq_needs_enable: assert property (!ien_ff |-> !irq_req)
        else $error("interrupt request while disabled");
    a_ack_clears_irq: assert property ((irq_ack && !core_enable) |=> !irq_req)
        else $error("interrupt request survived acknowledge");
endmodule : acr_checker

bind acr_top acr_checker u_checker (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
    .irq_req(irq_req), .core_req(core_req), .core_enable(core_enable),
    .active_channel(active_channel)
);
`default_nettype wire

// ---- bench/acr_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module acr_core_model (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    // Core side
    input  wire acr_pkg::acr_core_req_s core_req,
    input  wire logic [9:0]             next_result,
    output logic [9:0]                  core_result,
    // Amplifier clock
    output logic                        amp_clk_event,
    output logic                        amp_phase_high
);
    logic [2:0] phase_ff;
    logic [9:0] held_ff;

    // Amplifier clock at one eighth of the system clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= 3'h0;
        end else begin
            phase_ff <= phase_ff + 3'h1;
        end
    end

    // Sample is taken when the conversion begins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_ff <= 10'h000;
        end else if (core_req.start) begin
            held_ff <= next_result;
        end
    end

    assign amp_clk_event  = (phase_ff == 3'h7);
    assign amp_phase_high = phase_ff[2];
    assign core_result    = held_ff;
endmodule : acr_core_model
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [2:0] A_IS = acr_pkg::ADDR_INPUT_SELECT;
    localparam logic [2:0] A_CA = acr_pkg::ADDR_CONTROL_A;
    localparam logic [2:0] A_CB = acr_pkg::ADDR_CONTROL_B;
    localparam logic [2:0] A_RL = acr_pkg::ADDR_RESULT_LOW;
    localparam logic [2:0] A_RH = acr_pkg::ADDR_RESULT_HIGH;

    logic                   core_clk     = 1'h0;
    logic                   arst_n       = 1'h0;
    logic [2:0]             reg_addr     = 3'h0;
    logic [7:0]             reg_wdata    = 8'h00;
    logic                   reg_wr       = 1'h0;
    logic                   reg_rd       = 1'h0;
    logic                   irq_ack      = 1'h0;
    logic [15:0]            trig_sources = 16'h0000;
    logic [9:0]             next_result  = 10'h000;
    logic [7:0]             reg_rdata;
    logic                   irq_req, core_enable, amp_clk_event, amp_phase_high;
    logic [9:0]             core_result, res;
    logic [3:0]             active_channel;
    acr_pkg::acr_core_req_s core_req, req_seen;
    logic [15:0]            exp_q[$];
    logic [15:0]            note;
    logic                   rd_d = 1'h0;
    int                     num_errors = 0, checked = 0, n_starts = 0, cyc_cnt = 0;
    int                     start_cyc = 0, n0, dv, span;
    bit                     got;

    always #20 core_clk = ~core_clk;

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checked=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        reg_rd    <= 1'h0;
        @(posedge core_clk);
    endtask : wr

    // Expected read data is queued with a mask of the bits that matter
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e & m});
        reg_addr <= a;
        reg_wr   <= 1'h0;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
    endtask : rd

    task automatic idle(input int n);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic wait_irq(input int n);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        got = 0;
        while (!got && n > 0) begin
            @(posedge core_clk);
            got = (irq_req === 1'h1);
            n--;
        end
    endtask : wait_irq

    task automatic pulse(input logic [15:0] src);
        trig_sources <= src;
        idle(1);
        trig_sources <= 16'h0000;
    endtask : pulse

    task automatic ack_off();
        wr(A_CA, 8'h08);
        irq_ack <= 1'h1;
        idle(1);
        irq_ack <= 1'h0;
    endtask : ack_off

    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        rd_d    <= reg_rd;
        if (core_req.start === 1'h1) begin
            n_starts  <= n_starts + 1;
            start_cyc <= cyc_cnt;
            req_seen  <= core_req;
        end
    end

    always @(negedge core_clk) begin
        if (rd_d === 1'h1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check({2'h0, reg_rdata & note[15:8]}, {2'h0, note[7:0]});
        end
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(94));
        repeat (10) @(posedge core_clk);
        arst_n <= 1'h1;
        @(posedge core_clk);
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00, 8'hFF);
        $display("test reset values done");

        res = 10'($urandom);
        next_result <= res;
        wr(A_CB, 8'h80);
        wr(A_CA, 8'hC8);
        idle(1);
        wr(A_IS, 8'h05);
        rd(A_CA, 8'h40, 8'h40);
        wr(A_CA, 8'h88);
        rd(A_CA, 8'hC8, 8'hF8);
        check(active_channel, 10'h000);
        wait_irq(400);
        check(got, 1'h1);
        check(active_channel, 10'h005);
        check({req_seen.init, req_seen.high_speed, req_seen.channel}, 10'h030);
        rd(A_CA, 8'h98, 8'hFF);
        rd(A_RL, res[7:0], 8'hFF);
        rd(A_RH, {6'h00, res[9:8]}, 8'hFF);
        wr(A_IS, 8'h25);
        rd(A_RL, {res[1:0], 6'h00}, 8'hFF);
        rd(A_RH, res[9:2], 8'hFF);
        wr(A_CA, 8'h88);
        rd(A_CA, 8'h98, 8'hFF);
        irq_ack <= 1'h1;
        idle(1);
        irq_ack <= 1'h0;
        rd(A_CA, 8'h88, 8'hFF);
        $display("test single conversion done");

        rd(A_RL, {res[1:0], 6'h00}, 8'hFF);
        next_result <= ~res;
        wr(A_CA, 8'hC8);
        wait_irq(400);
        check({got, req_seen.init, req_seen.channel}, 10'h025);
        rd(A_RH, res[9:2], 8'hFF);
        wr(A_CA, 8'h98);
        rd(A_CA, 8'h88, 8'hFF);
        ack_off();
        $display("test result lock done");

        for (int p = 0; p < 8; p++) begin
            wr(A_CA, {5'h19, p[2:0]});
            wait_irq(2200);
            dv   = (p < 2) ? 2 : (1 << p);
            span = cyc_cnt - start_cyc;
            check(got && span >= 13 * dv && span <= 15 * dv + 4, 1'h1);
            check(req_seen.init, 1'h1);
            ack_off();
        end
        $display("test prescaler done");

        wr(A_IS, 8'h2B);
        wr(A_CA, 8'h88);
        wr(A_CB, 8'h90);
        wait_irq(400);
        check({got, req_seen.channel}, 10'h01B);
        rd(A_CB, 8'h80, 8'hFF);
        ack_off();
        $display("test amplified request done");

        wr(A_CB, 8'h01);
        wr(A_CA, 8'h88);
        n0 = n_starts;
        pulse(16'h0002);
        idle(8);
        check(n_starts - n0, 10'h000);
        wr(A_CA, 8'hA8);
        for (int c = 1; c < 13; c++) begin
            wr(A_CB, c[7:0]);
            n0 = n_starts;
            pulse(16'h0001 << ((c % 12) + 1));
            idle(8);
            check(n_starts - n0, 10'h000);
            pulse(16'h0001 << c);
            wait_irq(400);
            check(got && n_starts - n0 == 1, 1'h1);
            wr(A_CA, 8'hB8);
        end
        $display("test trigger sources done");

        wr(A_CB, 8'h00);
        n0 = n_starts;
        wr(A_CA, 8'hE8);
        wait_irq(400);
        idle(4);
        wr(A_CA, 8'h18);
        idle(2);
        check(core_enable, 1'h1);
        wait_irq(400);
        idle(2);
        check({got, core_enable}, 10'h002);
        check(n_starts - n0, 10'h002);
        $display("test free running done");
        stop_test();
    end

    acr_top u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
        .irq_req(irq_req), .trig_sources(trig_sources), .amp_clk_event(amp_clk_event),
        .amp_phase_high(amp_phase_high), .core_result(core_result), .core_req(core_req),
        .core_enable(core_enable), .active_channel(active_channel)
    );

    acr_core_model u_core (
        .core_clk(core_clk), .arst_n(arst_n), .core_req(core_req), .next_result(next_result),
        .core_result(core_result), .amp_clk_event(amp_clk_event),
        .amp_phase_high(amp_phase_high)
    );
endmodule : tb
`default_nettype wire

// ---- hw/acr_pkg.sv ----
package acr_pkg;

    // Register addresses on the plain register port; none are printed, so these are our own
    localparam logic [2:0] ADDR_INPUT_SELECT = 3'h0;
    localparam logic [2:0] ADDR_CONTROL_A    = 3'h1;
    localparam logic [2:0] ADDR_CONTROL_B    = 3'h2;
    localparam logic [2:0] ADDR_RESULT_LOW   = 3'h3;
    localparam logic [2:0] ADDR_RESULT_HIGH  = 3'h4;

    // Field positions in converter_control_a
    localparam int CA_ENABLE   = 7;
    localparam int CA_START    = 6;
    localparam int CA_AUTO     = 5;
    localparam int CA_DONE     = 4;
    localparam int CA_IRQ_EN   = 3;

    // Field positions in converter_control_b
    localparam int CB_HIGH_SPEED = 7;
    localparam int CB_AMP_REQ    = 4;

    // Field positions in input_select_register
    localparam int IS_LEFT_ADJ = 5;

    // Values after reset
    localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
    localparam logic [7:0] RST_CONTROL_A    = 8'h00;
    localparam logic [7:0] RST_CONTROL_B    = 8'h00;
    localparam logic [9:0] RST_RESULT       = 10'h000;

    // Conversion lengths in converter clock cycles
    localparam logic [4:0] CONV_CYCLES     = 5'h0D;
    localparam logic [4:0] CONV_CYCLES_AMP = 5'h0E;
    localparam logic [4:0] INIT_CYCLES     = 5'h0C;

    // Trigger source codes
    localparam logic [3:0] TRIG_FREE_RUN = 4'h0;
    localparam logic [3:0] TRIG_PSC_LO   = 4'h8;
    localparam logic [3:0] TRIG_PSC_HI   = 4'hA;
    localparam logic [3:0] TRIG_RESV_LO  = 4'hD;

    // Channel codes
    localparam logic [3:0] CHAN_AMP_ZERO = 4'hB;
    localparam logic [3:0] CHAN_AMP_ONE  = 4'hC;
    localparam logic [3:0] CHAN_RESERVED = 4'hD;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_AMP,
        ST_CONVERT
    } acr_state_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acr_bus_s;

    typedef struct packed {
        logic       start;
        logic [3:0] channel;
        logic       init;
        logic       high_speed;
    } acr_core_req_s;

endpackage : acr_pkg

// ---- hw/acr_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module acr_prescaler (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Control
    input  wire logic [2:0] prescale_sel,
    // Converter clock enable
    output logic            tick
);
    logic [6:0] count_ff;
    logic [6:0] limit;

    // Codes 0 and 1 both divide by two
    always_comb begin
        case (prescale_sel)
            3'h0, 3'h1: limit = 7'h01;
            3'h2:       limit = 7'h03;
            3'h3:       limit = 7'h07;
            3'h4:       limit = 7'h0F;
            3'h5:       limit = 7'h1F;
            3'h6:       limit = 7'h3F;
            default:    limit = 7'h7F;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= 7'h00;
        end else if (count_ff >= limit) begin
            count_ff <= 7'h00;
        end else begin
            count_ff <= count_ff + 7'h01;
        end
    end

    assign tick = (count_ff >= limit);
endmodule : acr_prescaler
`default_nettype wire

// ---- hw/acr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module acr_top (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    // Register port
    input  wire logic [2:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    // Interrupt controller
    input  wire logic               irq_ack,
    output logic                    irq_req,
    // Trigger sources, bit n is trigger code n
    input  wire logic [15:0]        trig_sources,
    // Amplifier synchronization
    input  wire logic               amp_clk_event,
    input  wire logic               amp_phase_high,
    // Analog core
    input  wire logic [9:0]         core_result,
    output acr_pkg::acr_core_req_s  core_req,
    output logic                    core_enable,
    output logic [3:0]              active_channel
);
    acr_pkg::acr_bus_s    bus;
    acr_pkg::acr_state_e  state_ff;
    logic [7:0]  in_sel_ff;
    logic [3:0]  chan_ff;
    logic        enable_ff;
    logic        start_ff;
    logic        auto_ff;
    logic        done_ff;
    logic        irq_en_ff;
    logic [2:0]  prescale_ff;
    logic        high_speed_ff;
    logic        amp_req_ff;
    logic [3:0]  trig_sel_ff;
    logic [9:0]  result_ff;
    logic        lock_ff;
    logic        need_init_ff;
    logic        init_ff;
    logic [4:0]  cyc_ff;
    logic [4:0]  cyc_target_ff;
    logic [7:0]  rdata_ff;
    logic        tick;
    logic        trig_fire;
    logic        busy;
    logic        finish;
    logic        go;
    logic        wr_a;
    logic        wr_b;
    logic        wr_sel;
    logic        free_retrigger;
    logic [7:0]  res_high;
    logic [7:0]  res_low;
    logic        left_adj;
    logic [7:0]  nxt_rdata;
    logic        amp_chan;
    logic        long_conv;
    logic        last_tick;
    logic        rd_low;
    logic        rd_high;
    logic        clr_done;
    logic        trig_go;
    logic        amp_go;

    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr    = reg_wr;
    assign bus.rd    = reg_rd;

    assign wr_sel = bus.wr && (bus.addr == acr_pkg::ADDR_INPUT_SELECT);
    assign wr_a   = bus.wr && (bus.addr == acr_pkg::ADDR_CONTROL_A);
    assign wr_b   = bus.wr && (bus.addr == acr_pkg::ADDR_CONTROL_B);
    assign busy   = (state_ff != acr_pkg::ST_IDLE);
    assign last_tick = (cyc_ff == cyc_target_ff);
    assign finish = (state_ff == acr_pkg::ST_CONVERT) && tick && last_tick;
    assign left_adj = in_sel_ff[acr_pkg::IS_LEFT_ADJ];
    assign rd_low   = bus.rd && (bus.addr == acr_pkg::ADDR_RESULT_LOW);
    assign rd_high  = bus.rd && (bus.addr == acr_pkg::ADDR_RESULT_HIGH);
    assign clr_done = irq_ack || (wr_a && bus.wdata[acr_pkg::CA_DONE]);

    // Amplified channels started in the high phase need one more cycle
    assign amp_chan  = (in_sel_ff[3:0] == acr_pkg::CHAN_AMP_ZERO) ||
                       (in_sel_ff[3:0] == acr_pkg::CHAN_AMP_ONE);
    assign long_conv = amp_chan && amp_phase_high;

    // Converter clock enable, one pulse per converter clock
    acr_prescaler u_prescaler (
        .core_clk     (core_clk),
        .arst_n       (arst_n),
        .prescale_sel (prescale_ff),
        .tick         (tick)
    );

    // Edge or event detection per trigger code
    acr_trigger u_trigger (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .sources    (trig_sources),
        .source_sel (trig_sel_ff),
        .fire       (trig_fire)
    );

    // Free running restarts after each completion while the start bit was set once
    assign free_retrigger = auto_ff && (trig_sel_ff == acr_pkg::TRIG_FREE_RUN) && finish;

    // Start when idle: software start, or a trigger only in auto mode
    assign trig_go = auto_ff && trig_fire;
    assign go      = !busy && enable_ff && (start_ff || trig_go);
    // The amplified request waits for an amplifier clock event while idle
    assign amp_go  = amp_req_ff && amp_clk_event && !busy;

    // Input select register; the channel copy only updates between conversions
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            in_sel_ff <= acr_pkg::RST_INPUT_SELECT;
        end else if (wr_sel) begin
            // Bit 4 is not implemented and reads zero
            in_sel_ff <= bus.wdata & 8'hEF;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_ff <= 4'h0;
        end else if (!busy || finish) begin
            chan_ff <= in_sel_ff[3:0];
        end
    end

    // Enable bit; the core stays powered until a running conversion ends
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_ff <= 1'b0;
        end else if (wr_a) begin
            enable_ff <= bus.wdata[acr_pkg::CA_ENABLE];
        end
    end

    assign core_enable = enable_ff || busy;

    // Initialization is owed again whenever the converter is switched off
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            need_init_ff <= 1'b1;
        end else if (!enable_ff && !busy) begin
            need_init_ff <= 1'b1;
        end else if (go) begin
            need_init_ff <= 1'b0;
        end
    end

    // Start bit: set by software or by the amplified request, cleared at completion unless free running
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_ff <= 1'b0;
        end else if (finish && !free_retrigger) begin
            start_ff <= 1'b0;
        end else if (wr_a && bus.wdata[acr_pkg::CA_START]) begin
            start_ff <= 1'b1;
        end else if (amp_go) begin
            start_ff <= 1'b1;
        end else if (!enable_ff && !busy) begin
            start_ff <= 1'b0;
        end
    end

    // Remaining control A fields
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_ff     <= acr_pkg::RST_CONTROL_A[acr_pkg::CA_AUTO];
            irq_en_ff   <= acr_pkg::RST_CONTROL_A[acr_pkg::CA_IRQ_EN];
            prescale_ff <= acr_pkg::RST_CONTROL_A[2:0];
        end else if (wr_a) begin
            auto_ff     <= bus.wdata[acr_pkg::CA_AUTO];
            irq_en_ff   <= bus.wdata[acr_pkg::CA_IRQ_EN];
            prescale_ff <= bus.wdata[2:0];
        end
    end

    // Completion flag: a new completion wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_ff <= 1'b0;
        end else if (finish) begin
            done_ff <= 1'b1;
        end else if (clr_done) begin
            done_ff <= 1'b0;
        end
    end

    assign irq_req = irq_en_ff && done_ff;

    // Control B
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            high_speed_ff <= acr_pkg::RST_CONTROL_B[acr_pkg::CB_HIGH_SPEED];
            trig_sel_ff   <= acr_pkg::RST_CONTROL_B[3:0];
        end else if (wr_b) begin
            high_speed_ff <= bus.wdata[acr_pkg::CB_HIGH_SPEED];
            trig_sel_ff   <= bus.wdata[3:0];
        end
    end

    // Amplified request: cleared once its conversion starts, or by a zero write
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            amp_req_ff <= acr_pkg::RST_CONTROL_B[acr_pkg::CB_AMP_REQ];
        end else if (go) begin
            amp_req_ff <= 1'b0;
        end else if (wr_b) begin
            amp_req_ff <= bus.wdata[acr_pkg::CB_AMP_REQ];
        end
    end

    // Conversion sequencer counting converter clock ticks
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff      <= acr_pkg::ST_IDLE;
            cyc_ff        <= 5'h00;
            cyc_target_ff <= acr_pkg::CONV_CYCLES;
            init_ff       <= 1'b0;
        end else begin
            case (state_ff)
                acr_pkg::ST_IDLE: begin
                    if (go) begin
                        state_ff <= acr_pkg::ST_WAIT_AMP;
                        cyc_ff   <= 5'h00;
                        init_ff  <= need_init_ff;
                        if (long_conv) begin
                            cyc_target_ff <= acr_pkg::CONV_CYCLES_AMP;
                        end else begin
                            cyc_target_ff <= acr_pkg::CONV_CYCLES;
                        end
                    end
                end
                acr_pkg::ST_WAIT_AMP: begin
                    if (tick) begin
                        state_ff <= acr_pkg::ST_CONVERT;
                        cyc_ff   <= 5'h01;
                    end
                end
                acr_pkg::ST_CONVERT: begin
                    if (finish) begin
                        // Free running restarts through idle so every start is announced
                        state_ff <= acr_pkg::ST_IDLE;
                        cyc_ff   <= 5'h00;
                        init_ff  <= 1'b0;
                    end else if (tick) begin
                        cyc_ff <= cyc_ff + 5'h01;
                    end
                end
                default: begin
                    state_ff <= acr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign core_req.start      = go;
    assign core_req.channel    = in_sel_ff[3:0];
    assign core_req.init       = init_ff || (go && need_init_ff);
    assign core_req.high_speed = high_speed_ff;
    assign active_channel      = chan_ff;

    // Result capture; a low-byte read holds the pair until the high byte is read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_ff <= acr_pkg::RST_RESULT;
        end else if (finish && !lock_ff) begin
            result_ff <= core_result;
        end
    end

    // Reading the high byte releases the hold
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_ff <= 1'b0;
        end else if (rd_high) begin
            lock_ff <= 1'b0;
        end else if (rd_low) begin
            lock_ff <= 1'b1;
        end
    end

    // Byte layout follows the adjust bit at all times
    assign res_high = left_adj ? result_ff[9:2] : {6'h00, result_ff[9:8]};
    assign res_low  = left_adj ? {result_ff[1:0], 6'h00} : result_ff[7:0];

    always_comb begin
        case (bus.addr)
            acr_pkg::ADDR_INPUT_SELECT: nxt_rdata = in_sel_ff;
            acr_pkg::ADDR_CONTROL_A:    nxt_rdata = {enable_ff, start_ff, auto_ff, done_ff,
                                                     irq_en_ff, prescale_ff};
            acr_pkg::ADDR_CONTROL_B:    nxt_rdata = {high_speed_ff, 2'h0, amp_req_ff,
                                                     trig_sel_ff};
            acr_pkg::ADDR_RESULT_LOW:   nxt_rdata = res_low;
            acr_pkg::ADDR_RESULT_HIGH:  nxt_rdata = res_high;
            default:                    nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
        end else if (bus.rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule : acr_top
`default_nettype wire

// ---- hw/acr_trigger.sv ----
`timescale 1ns/1ps
`default_nettype none
module acr_trigger (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Sources, one bit per trigger code
    input  wire logic [15:0] sources,
    input  wire logic [3:0]  source_sel,
    // Start pulse for the selected source
    output logic             fire
);
    logic [15:0] prev_ff;
    logic [15:0] event_hit;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= 16'h0000;
        end else begin
            prev_ff <= sources;
        end
    end

    // Flag sources start on the rising edge; power stage events are pulses taken as given
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_src
            if (i >= 8 && i <= 10) begin : g_evt
                assign event_hit[i] = sources[i];
            end else if (i == 0 || i >= 13) begin : g_none
                assign event_hit[i] = 1'b0;
            end else begin : g_edge
                assign event_hit[i] = sources[i] & ~prev_ff[i];
            end
        end
    endgenerate

    assign fire = event_hit[source_sel];
endmodule : acr_trigger
`default_nettype wire
